// >>> lcdc_pkg.sv
// package: command codes, field positions, reset values and timing for the lcd command decoder
package lcdc_pkg;
   // command opcodes and masks
   localparam logic [7:0] DISP_ONOFF_OP  = 8'hAE;
   localparam logic [7:0] ADC_OP         = 8'hA0;
   localparam logic [7:0] BIAS_OP        = 8'hA2;
   localparam logic [7:0] ENTIRE_OP      = 8'hA4;
   localparam logic [7:0] REVERSE_OP     = 8'hA6;
   localparam logic [7:0] STATIC_OP      = 8'hAC;
   localparam logic [7:0] MASK_D0        = 8'hFE;
   localparam logic [7:0] RMW_ENTER      = 8'hE0;
   localparam logic [7:0] RMW_END        = 8'hEE;
   localparam logic [7:0] RESET_CMD      = 8'hE2;
   localparam logic [7:0] TEST_CLR       = 8'hF0;
   localparam logic [7:0] MASK_HI4       = 8'hF0;
   localparam logic [7:0] TEST_OP        = 8'hF0;
   localparam logic [7:0] PAGE_OP        = 8'hB0;
   localparam logic [7:0] COLHI_OP       = 8'h10;
   localparam logic [7:0] COLLO_OP       = 8'h00;
   localparam logic [7:0] COMDIR_OP      = 8'hC0;
   localparam logic [7:0] POWER_OP       = 8'h28;
   localparam logic [7:0] MASK_HI5       = 8'hF8;
   localparam logic [7:0] CONTRAST_OP    = 8'h80;
   localparam logic [7:0] MASK_HI3       = 8'hE0;
   localparam logic [7:0] START_OP       = 8'h40;
   localparam logic [7:0] MASK_HI2       = 8'hC0;
   // field positions
   localparam int COMDIR_BIT = 3;
   localparam int BUSY_BIT   = 7;
   localparam int ADC_BIT    = 6;
   localparam int OFF_BIT    = 5;
   localparam int RST_BIT    = 4;
   // widths and reset values
   localparam int START_W    = 6;
   localparam int PAGE_W     = 4;
   localparam int COL_W      = 8;
   localparam int POWER_W    = 3;
   localparam int CONTR_W    = 5;
   localparam logic [5:0] START_RST    = 6'h00;
   localparam logic [3:0] PAGE_RST     = 4'h0;
   localparam logic [7:0] COL_RST      = 8'h00;
   localparam logic [2:0] POWER_RST    = 3'h0;
   localparam logic [4:0] CONTR_RST    = 5'h00;
   localparam logic [3:0] STATUS_LOW   = 4'h0;
   // display ram geometry: 9 pages of 132 columns
   localparam int RAM_PAGES   = 9;
   localparam int RAM_COLS    = 132;
   localparam int RAM_AW      = 11;
   // reset-in-progress time (ns) and its cycle count at 200 MHz
   localparam int CLK_PERIOD_PS = 5000;
   localparam int RESET_TIME_NS = 1000;
   localparam int RESET_CYCLES  = (RESET_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // power-save state
   typedef enum logic [1:0] {PS_RUN, PS_SLEEP, PS_STANDBY} lcdc_ps_t;
endpackage

// >>> lcdc_sync.sv
// two-flop synchroniser for one pin level
`timescale 1ns/100ps
`default_nettype none
module lcdc_sync #(
   parameter logic INIT = 1'b0
) (
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic pinIn,
   output logic      pinSync
);
   logic firstStage_reg;

   ////////////////////////////////////////////////////////////////////////////
   // first stage feeds only the second
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         firstStage_reg <= INIT;
         pinSync        <= INIT;
      end else begin
         firstStage_reg <= pinIn;
         pinSync        <= firstStage_reg;
      end
   end
endmodule
`default_nettype wire

// >>> lcdc_ram.sv
// display ram: one write port, registered read port
`timescale 1ns/100ps
`default_nettype none
module lcdc_ram #(
   parameter int DEPTH = 1188,
   parameter int AW    = 11
) (
   input  wire logic          sys_clk,
   input  wire logic          wrEn,
   input  wire logic [AW-1:0] wrAddr,
   input  wire logic [7:0]    wrData,
   input  wire logic [AW-1:0] rdAddr,
   output logic      [7:0]    rdData
);
   logic [7:0] mem [DEPTH];

   ////////////////////////////////////////////////////////////////////////////
   // contents survive every reset, so no reset here
   always_ff @(posedge sys_clk) begin
      if (wrEn && (int'(wrAddr) < DEPTH)) begin
         mem[wrAddr] <= wrData;
      end
      rdData <= (int'(rdAddr) < DEPTH) ? mem[rdAddr] : 8'h00;
   end
endmodule
`default_nettype wire

// >>> lcdc_decoder.sv
// command decoder and power-save state for a ram-mapped dot-matrix lcd controller
// Operation
// - display on/off from byte 1010111D
// - 01xxxxxx loads display start line
// - 1011xxxx loads page address
// - 0001/0000 load column high/low nibble
// - status read, low four bits zero
// - data select high accesses display ram
// - 1010000D sets segment direction
// - 1010011D sets normal/reverse display
// - 1010010D forces every pixel on
// - 1010001D stores bias ratio bit
// - E0 enters, EE leaves read-modify-write
// - 1100Dxxx stores common scan direction
// - 00101xxx loads power circuit status
// - 100xxxxx loads contrast value
// - 1010110D sets static indicator
// - display off then entire on means save
// - save enters sleep or standby; on releases
// - sleep stops oscillator, supply, grounds outputs
// - standby stops supply, indicator keeps running
// - reset command in standby enters sleep
// - 1111xxxx test mode, reset exits
// - F0 clears test mode
// - reset command restores line, column, page, direction
// - leaving read-modify-write restores column
// - status busy, adc, off, reset; busy rejects
`timescale 1ns/100ps
`default_nettype none
module lcdc_decoder
   import lcdc_pkg::*;
#(
   parameter int RST_CYC = RESET_CYCLES
) (
   input  wire logic         sys_clk,
   input  wire logic         nrst,
   input  wire logic         hardware_reset_n,
   input  wire logic         cmd_data_select,
   input  wire logic         wrStrobe,
   input  wire logic         rdStrobe,
   input  wire logic [7:0]   dataIn,
   output logic      [7:0]   dataOut,
   output logic              dataOutEn,
   output logic              displayOn,
   output logic [5:0]        startLine,
   output logic [3:0]        pageAddr,
   output logic [7:0]        colAddr,
   output logic              segReverse,
   output logic              reverseDisplay,
   output logic              entireOn,
   output logic              biasSel,
   output logic              rmwMode,
   output logic              comReverse,
   output logic [2:0]        powerCtrl,
   output logic [4:0]        contrast,
   output logic              staticInd,
   output logic              sleepMode,
   output logic              standbyMode,
   output logic              oscRun,
   output logic              supplyRun,
   output logic              outputsGround,
   output logic              staticDriveRun,
   output logic              testMode,
   output logic              busy
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and strobe edge detection
   logic       resPinS, cdsS, wrS, rdS;
   logic [7:0] dataS;
   logic       wr_reg, rd_reg;
   lcdc_sync #(.INIT(1'b1)) uRes (.sys_clk(sys_clk), .nrst(nrst), .pinIn(hardware_reset_n),
                                  .pinSync(resPinS));
   lcdc_sync #(.INIT(1'b0)) uCds (.sys_clk(sys_clk), .nrst(nrst), .pinIn(cmd_data_select),
                                  .pinSync(cdsS));
   lcdc_sync #(.INIT(1'b0)) uWr (.sys_clk(sys_clk), .nrst(nrst), .pinIn(wrStrobe),
                                 .pinSync(wrS));
   lcdc_sync #(.INIT(1'b0)) uRd (.sys_clk(sys_clk), .nrst(nrst), .pinIn(rdStrobe),
                                 .pinSync(rdS));
   // data bits settle well before a strobe edge, so syncing each bit alone cannot tear a byte
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : gData
         lcdc_sync #(.INIT(1'b0)) uD (.sys_clk(sys_clk), .nrst(nrst), .pinIn(dataIn[gi]),
                                      .pinSync(dataS[gi]));
      end
   endgenerate

   // strobes are active high; act once per strobe on the rising edge
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
      end else begin
         wr_reg <= wrS;
         rd_reg <= rdS;
      end
   end

   logic wrEvt, rdEvt, hwReset;
   assign hwReset = !resPinS;
   assign wrEvt   = wrS && !wr_reg;
   assign rdEvt   = rdS && !rd_reg;

   ////////////////////////////////////////////////////////////////////////////
   // busy / reset-in-progress counter
   logic [15:0] rstCnt_reg;
   logic        cmdWr, dataWr, dataRd, statRd;
   logic        isReset;
   assign cmdWr   = wrEvt && !cdsS && !busy;
   assign dataWr  = wrEvt && cdsS && !busy;
   assign dataRd  = rdEvt && cdsS;
   assign statRd  = rdEvt && !cdsS;
   assign isReset = cmdWr && (dataS == RESET_CMD);

   // busy holds while the reset sequence runs; commands are dropped meanwhile
   // reads are not gated by busy, so the host can poll status during a reset
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rstCnt_reg <= 16'h0000;
         busy       <= 1'b0;
      end else if (hwReset || isReset) begin
         rstCnt_reg <= 16'(RST_CYC);
         busy       <= 1'b1;
      end else if (rstCnt_reg != 16'h0000) begin
         rstCnt_reg <= rstCnt_reg - 16'h0001;
         busy       <= (rstCnt_reg != 16'h0001);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // display mode registers; hardware reset restores defaults
   // supply settings and contrast clear only on the pin; the reset command keeps them
   always_ff @(posedge sys_clk) begin
      if (!nrst || hwReset) begin
         displayOn      <= 1'b0;
         segReverse     <= 1'b0;
         reverseDisplay <= 1'b0;
         entireOn       <= 1'b0;
         biasSel        <= 1'b0;
         staticInd      <= 1'b0;
         powerCtrl      <= POWER_RST;
         contrast       <= CONTR_RST;
      end else if (cmdWr) begin
         if ((dataS & MASK_D0) == DISP_ONOFF_OP) displayOn <= dataS[0];
         if ((dataS & MASK_D0) == ADC_OP) segReverse <= dataS[0];
         if ((dataS & MASK_D0) == REVERSE_OP) reverseDisplay <= dataS[0];
         if ((dataS & MASK_D0) == ENTIRE_OP) entireOn <= dataS[0];
         if ((dataS & MASK_D0) == BIAS_OP) biasSel <= dataS[0];
         if ((dataS & MASK_D0) == STATIC_OP) staticInd <= dataS[0];
         if ((dataS & MASK_HI5) == POWER_OP) powerCtrl <= dataS[POWER_W-1:0];
         if ((dataS & MASK_HI3) == CONTRAST_OP) contrast <= dataS[CONTR_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // addressing registers, cleared by either reset
   logic [7:0] colSave_reg;
   logic       colStep;
   // read-modify-write stops reads from advancing the column
   assign colStep = dataWr || (dataRd && !rmwMode);
   // the column saturates at its last value instead of wrapping to zero
   // the restore on read-modify-write end is written last so it beats a column set

   always_ff @(posedge sys_clk) begin
      if (!nrst || hwReset || isReset) begin
         startLine  <= START_RST;
         pageAddr   <= PAGE_RST;
         colAddr    <= COL_RST;
         comReverse <= 1'b0;
      end else if (cmdWr) begin
         if ((dataS & MASK_HI2) == START_OP) startLine <= dataS[START_W-1:0];
         if ((dataS & MASK_HI4) == PAGE_OP) pageAddr <= dataS[PAGE_W-1:0];
         if ((dataS & MASK_HI4) == COLHI_OP) colAddr <= {dataS[3:0], colAddr[3:0]};
         if ((dataS & MASK_HI4) == COLLO_OP) colAddr <= {colAddr[7:4], dataS[3:0]};
         if ((dataS & MASK_HI4) == COMDIR_OP) comReverse <= dataS[COMDIR_BIT];
         if (dataS == RMW_END && rmwMode) colAddr <= colSave_reg;
      end else if (colStep && colAddr < 8'(RAM_COLS - 1)) begin
         colAddr <= colAddr + 8'h01;
      end
   end

   // rmw flag and saved column; undefined bytes fall through untouched
   // a second enter while already in the mode saves the column again
   always_ff @(posedge sys_clk) begin
      if (!nrst || hwReset) begin
         rmwMode     <= 1'b0;
         colSave_reg <= COL_RST;
      end else if (cmdWr && dataS == RMW_ENTER) begin
         rmwMode     <= 1'b1;
         colSave_reg <= colAddr;
      end else if (cmdWr && dataS == RMW_END) begin
         rmwMode     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // test mode: any 1111xxxx sets, F0 or resets clear
   // F0 also lies in the 1111 range, so its clear is tested before the set
   always_ff @(posedge sys_clk) begin
      if (!nrst || hwReset || isReset) begin
         testMode <= 1'b0;
      end else if (cmdWr && dataS == TEST_CLR) begin
         testMode <= 1'b0;
      end else if (cmdWr && (dataS & MASK_HI4) == TEST_OP) begin
         testMode <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // power save: display off plus entire-on is the request
   lcdc_ps_t psState_reg;
   logic     saveReq, saveRel;
   // request when entire-on arrives with display off, or display-off with entire-on set
   // both byte orders count, so a host may send the pair either way round
   assign saveReq = cmdWr && (
         (dataS == (ENTIRE_OP | 8'h01) && !displayOn) ||
         (dataS == DISP_ONOFF_OP && entireOn));
   assign saveRel = cmdWr && (dataS == (DISP_ONOFF_OP | 8'h01) || dataS == ENTIRE_OP);

   always_ff @(posedge sys_clk) begin
      if (!nrst || hwReset) begin
         psState_reg <= PS_RUN;
      end else begin
         case (psState_reg)
            PS_RUN: begin
               if (saveReq) begin
                  psState_reg <= staticInd ? PS_STANDBY : PS_SLEEP;
               end
            end
            PS_SLEEP: begin
               if (saveRel) psState_reg <= PS_RUN;
            end
            PS_STANDBY: begin
               if (saveRel) begin
                  psState_reg <= PS_RUN;
               end else if (isReset) begin
                  psState_reg <= PS_SLEEP;
               end
            end
            default: psState_reg <= PS_RUN;
         endcase
      end
   end

   // power outputs trail the state by one cycle so that each comes straight from a flop
   // outputs are grounded whenever the panel is off, even outside power save
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         sleepMode      <= 1'b0;
         standbyMode    <= 1'b0;
         oscRun         <= 1'b1;
         supplyRun      <= 1'b1;
         outputsGround  <= 1'b0;
         staticDriveRun <= 1'b0;
      end else begin
         sleepMode      <= (psState_reg == PS_SLEEP);
         standbyMode    <= (psState_reg == PS_STANDBY);
         oscRun         <= (psState_reg != PS_SLEEP);
         supplyRun      <= (psState_reg == PS_RUN);
         outputsGround  <= (psState_reg != PS_RUN) || !displayOn;
         staticDriveRun <= staticInd && (psState_reg != PS_SLEEP);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // display ram, reachable in every power state
   logic [RAM_AW-1:0] ramAddr;
   logic [7:0]        ramRd;
   assign ramAddr = RAM_AW'(pageAddr * RAM_COLS) + RAM_AW'(colAddr);
   // pages past the last one would alias onto low pages, so their writes are dropped
   logic              ramWrEn;
   assign ramWrEn = dataWr && (pageAddr < PAGE_W'(RAM_PAGES));
   lcdc_ram #(.DEPTH(RAM_PAGES * RAM_COLS), .AW(RAM_AW)) uRam (
      .sys_clk (sys_clk),
      .wrEn    (ramWrEn),
      .wrAddr  (ramAddr),
      .wrData  (dataS),
      .rdAddr  (ramAddr),
      .rdData  (ramRd)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read data: ram output is registered from the current column address, so each read returns that column's byte with no dummy read
   // status is built from stored flags alone, so it stays readable while busy
   logic [7:0] status;
   always_comb begin
      status              = {4'h0, STATUS_LOW};
      status[BUSY_BIT]    = busy;
      status[ADC_BIT]     = !segReverse;
      status[OFF_BIT]     = !displayOn;
      status[RST_BIT]     = busy;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         dataOut   <= 8'h00;
         dataOutEn <= 1'b0;
      end else begin
         if (statRd) dataOut <= status;
         else if (dataRd) dataOut <= ramRd;
         dataOutEn <= rdS;
      end
   end
endmodule
`default_nettype wire

// >>> lcdc_decoder_sva.sv
// checker: timing and power-state relations of the lcd command decoder
`timescale 1ns/100ps
`default_nettype none
module lcdc_decoder_sva #(
   parameter int RST_CYC = 200
) (
   input wire logic       sys_clk,
   input wire logic       nrst,
   input wire logic       hardware_reset_n,
   input wire logic       cmd_data_select,
   input wire logic       wrStrobe,
   input wire logic       rdStrobe,
   input wire logic [7:0] dataIn,
   input wire logic [7:0] dataOut,
   input wire logic       dataOutEn,
   input wire logic       displayOn,
   input wire logic [7:0] colAddr,
   input wire logic       segReverse,
   input wire logic       entireOn,
   input wire logic       rmwMode,
   input wire logic [4:0] contrast,
   input wire logic       staticInd,
   input wire logic       sleepMode,
   input wire logic       standbyMode,
   input wire logic       oscRun,
   input wire logic       supplyRun,
   input wire logic       outputsGround,
   input wire logic       staticDriveRun,
   input wire logic       busy
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   logic [7:0] colSaved_reg;
   // column held at entry to read-modify-write, for the restore check
   always_ff @(posedge sys_clk) begin
      if ($rose(rmwMode)) begin
         colSaved_reg <= colAddr;
      end
   end
   // pin-level write of the display-on byte while the device is free
   sequence s_on_write;
      !wrStrobe ##1 (wrStrobe && !cmd_data_select && dataIn == 8'hAF && !busy && hardware_reset_n);
   endsequence
   ////////////////////////////////////////////////////////////////////////////////////////
   a_display_cmd: assert property (s_on_write |-> ##[2:6] displayOn)
      else $error("display-on write not applied");
   a_status_read: assert property (dataOutEn && $past(dataOutEn) && !cmd_data_select
      && !$past(cmd_data_select, 4) |-> dataOut[3:0] == 4'h0 && dataOut[7] == dataOut[4]
      && dataOut[6] == !segReverse && dataOut[5] == !displayOn)
      else $error("status byte malformed");
   a_sleep_stop: assert property (sleepMode |-> !oscRun && !supplyRun && outputsGround
      && !staticDriveRun)
      else $error("sleep left circuits running");
   a_standby_drive: assert property (standbyMode |-> !supplyRun && outputsGround
      && staticDriveRun)
      else $error("standby power outputs wrong");
   a_save_entry: assert property ($rose(sleepMode || standbyMode) |-> !displayOn
      && entireOn)
      else $error("power save without display off and entire on");
   a_sleep_kind: assert property ($rose(sleepMode) |-> !staticInd || $past(standbyMode))
      else $error("sleep entered with indicator on");
   a_standby_kind: assert property ($rose(standbyMode) |-> staticInd)
      else $error("standby entered with indicator off");
   a_rmw_restore: assert property ($fell(rmwMode) && !busy |-> colAddr == colSaved_reg)
      else $error("column not restored after rmw end");
   a_busy_hold: assert property ((busy && hardware_reset_n)[*4] |=> $stable(contrast))
      else $error("command accepted while busy");
   a_read_enable: assert property (dataOutEn == $past(rdStrobe, 3))
      else $error("read enable out of step with read strobe");
endmodule
bind lcdc_decoder lcdc_decoder_sva #(.RST_CYC(RST_CYC)) u_sva (.sys_clk, .nrst,
   .hardware_reset_n, .cmd_data_select, .wrStrobe, .rdStrobe, .dataIn, .dataOut, .dataOutEn,
   .displayOn, .colAddr, .segReverse, .entireOn, .rmwMode, .contrast, .staticInd,
   .sleepMode, .standbyMode, .oscRun, .supplyRun, .outputsGround, .staticDriveRun, .busy);
`default_nettype wire

// >>> lcdc_host_model.sv
// host model: parallel-bus master issuing command, status and data cycles
`timescale 1ns/100ps
`default_nettype none
module lcdc_host_model (
   input  wire logic       sys_clk,
   input  wire logic [7:0] dataOut,
   output logic            cmd_data_select,
   output logic            wrStrobe,
   output logic            rdStrobe,
   output logic [7:0]      dataIn
);
   // idle bus: strobes low, data lines carry no meaning
   initial begin
      cmd_data_select = 1'b0;
      wrStrobe = 1'b0;
      rdStrobe = 1'b0;
      dataIn = 8'hFF;
   end
   // one strobe cycle; setup and hold cover the two-flop pin sync
   task automatic xfer(input logic cds, input logic wr, input logic [7:0] d,
                       output logic [7:0] q);
      @(negedge sys_clk);
      cmd_data_select = cds;
      dataIn = d;
      repeat (3) @(negedge sys_clk);
      wrStrobe = wr;
      rdStrobe = !wr;
      repeat (5) @(negedge sys_clk);
      q = dataOut;
      wrStrobe = 1'b0;
      rdStrobe = 1'b0;
      @(negedge sys_clk);
      dataIn = ~d; // hold time over: stale value must not be trusted
      repeat (3) @(negedge sys_clk);
   endtask
endmodule
`default_nettype wire

// >>> tb.sv
// testbench: command table sweep, then status, ram, power save, test mode, resets
`timescale 1ns/100ps
`default_nettype none
module tb;
   import lcdc_pkg::*;
   typedef struct packed {logic [7:0] cmd; logic [3:0] sel; logic [7:0] exp;} lcdc_row_t;
   localparam int RC = 40;
   logic sys_clk = 1'b0, nrst = 1'b0, hardware_reset_n = 1'b1;
   logic cmd_data_select, wrStrobe, rdStrobe, dataOutEn, displayOn, segReverse, biasSel;
   logic reverseDisplay, entireOn, rmwMode, comReverse, staticInd, sleepMode, standbyMode;
   logic oscRun, supplyRun, outputsGround, staticDriveRun, testMode, busy;
   logic [7:0] dataIn, dataOut, colAddr, rd;
   logic [5:0] startLine;
   logic [3:0] pageAddr;
   logic [2:0] powerCtrl;
   logic [4:0] contrast;
   int error_cnt = 0, tests_run = 0;
   lcdc_row_t rows [18] = '{'{8'hAF, 4'h0, 8'h01}, '{8'h7F, 4'h1, 8'h3F},
      '{8'hB8, 4'h2, 8'h08}, '{8'h18, 4'h3, 8'h80}, '{8'h03, 4'h3, 8'h83},
      '{8'hA1, 4'h4, 8'h01}, '{8'hA7, 4'h5, 8'h01}, '{8'hA5, 4'h6, 8'h01},
      '{8'hA4, 4'h6, 8'h00}, '{8'hA3, 4'h7, 8'h01}, '{8'hC7, 4'h8, 8'h00},
      '{8'hC8, 4'h8, 8'h01}, '{8'h2F, 4'h9, 8'h07}, '{8'h9F, 4'hA, 8'h1F},
      '{8'hAD, 4'hB, 8'h01}, '{8'hAC, 4'hB, 8'h00}, '{8'hA0, 4'h4, 8'h00},
      '{8'h33, 4'hA, 8'h1F}};
   always #2.5 sys_clk = ~sys_clk;
   lcdc_decoder #(.RST_CYC(RC)) u_lcdc_decoder (
      .sys_clk, .nrst, .hardware_reset_n, .cmd_data_select, .wrStrobe, .rdStrobe, .dataIn,
      .dataOut, .dataOutEn, .displayOn, .startLine, .pageAddr, .colAddr, .segReverse,
      .reverseDisplay, .entireOn, .biasSel, .rmwMode, .comReverse, .powerCtrl, .contrast,
      .staticInd, .sleepMode, .standbyMode, .oscRun, .supplyRun, .outputsGround,
      .staticDriveRun, .testMode, .busy);
   lcdc_host_model host (.sys_clk, .dataOut, .cmd_data_select, .wrStrobe, .rdStrobe, .dataIn);
   // pick one decoded output, zero-extended, by row selector
   function automatic logic [7:0] obs(input logic [3:0] s);
      case (s)
         4'h0: obs = {7'h00, displayOn};
         4'h1: obs = {2'h0, startLine};
         4'h2: obs = {4'h0, pageAddr};
         4'h3: obs = colAddr;
         4'h4: obs = {7'h00, segReverse};
         4'h5: obs = {7'h00, reverseDisplay};
         4'h6: obs = {7'h00, entireOn};
         4'h7: obs = {7'h00, biasSel};
         4'h8: obs = {7'h00, comReverse};
         4'h9: obs = {5'h00, powerCtrl};
         4'hA: obs = {3'h0, contrast};
         default: obs = {7'h00, staticInd};
      endcase
   endfunction
   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmd(input logic [7:0] b);
      host.xfer(1'b0, 1'b1, b, rd);
   endtask
   // busy after any reset lasts RC cycles; margin avoids refused commands
   task automatic idle();
      repeat (RC + 10) @(negedge sys_clk);
   endtask
   task automatic finish_test();
      if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   function automatic logic [7:0] pw();
      pw = {2'h0, sleepMode, standbyMode, oscRun, supplyRun, outputsGround, staticDriveRun};
   endfunction
   // watchdog: whole run needs well under 3000 cycles
   initial begin
      #100000;
      error_cnt++;
      finish_test();
   end
   initial begin
      repeat (16) @(negedge sys_clk);
      nrst = 1'b1;
      idle();
      chk({busy, displayOn, testMode, 3'h0, oscRun, outputsGround}, 8'h03);
      foreach (rows[i]) begin
         cmd(rows[i].cmd);
         chk(obs(rows[i].sel), rows[i].exp);
      end
      host.xfer(1'b0, 1'b0, 8'h00, rd);
      chk(rd, 8'h40);
      cmd(8'h10);
      cmd(8'h00);
      host.xfer(1'b1, 1'b1, 8'h5A, rd);
      host.xfer(1'b1, 1'b1, 8'hC3, rd);
      chk(colAddr, 8'h02);
      cmd(8'hE0);
      host.xfer(1'b1, 1'b0, 8'h00, rd);
      host.xfer(1'b1, 1'b1, 8'h77, rd);
      chk({rmwMode, colAddr[6:0]}, 8'h83);
      cmd(8'hEE);
      chk({rmwMode, colAddr[6:0]}, 8'h02);
      cmd(8'h00);
      host.xfer(1'b1, 1'b0, 8'h00, rd);
      host.xfer(1'b1, 1'b0, 8'h00, rd);
      chk(rd, 8'hC3);
      cmd(8'hAE);
      cmd(8'hA5);
      chk(pw(), 8'h22);
      cmd(8'hAF);
      chk(pw(), 8'h0C);
      cmd(8'hAD);
      cmd(8'hAE);
      cmd(8'hA5);
      chk(pw(), 8'h1B);
      cmd(8'hE2);
      cmd(8'h81);
      chk({sleepMode, standbyMode, busy, contrast}, 8'hBF);
      chk({comReverse, startLine, 1'b0}, 8'h00);
      chk({pageAddr, 4'h0}, 8'h00);
      host.xfer(1'b0, 1'b0, 8'h00, rd);
      chk(rd, 8'hF0);
      idle();
      cmd(8'hA4);
      chk(pw() & 8'h30, 8'h00);
      cmd(8'hF5);
      chk({7'h00, testMode}, 8'h01);
      cmd(8'hF0);
      chk({7'h00, testMode}, 8'h00);
      cmd(8'hF3);
      cmd(8'hE2);
      chk({7'h00, testMode}, 8'h00);
      idle();
      cmd(8'hF3);
      hardware_reset_n = 1'b0;
      repeat (20) @(negedge sys_clk);
      hardware_reset_n = 1'b1;
      idle();
      chk({testMode, 2'h0, contrast}, 8'h00);
      finish_test();
   end
endmodule
`default_nettype wire
